// [src/ldma_pkg.sv]
package ldma_pkg;
    // Register byte offsets (parameter channels and status)
    localparam logic [7:0] OFF_LSA = 8'h00;   // Local address channel
    localparam logic [7:0] OFF_EAH = 8'h04;   // High address word
    localparam logic [7:0] OFF_EAL = 8'h08;   // Low address word
    localparam logic [7:0] OFF_SIZE = 8'h0C;  // Size channel
    localparam logic [7:0] OFF_TAG = 8'h10;   // Tag group channel
    localparam logic [7:0] OFF_CMD = 8'h14;   // Class id and opcode
    localparam logic [7:0] OFF_STAT = 8'h18;  // Event and busy status
    localparam logic [7:0] OFF_ACK = 8'h1C;   // Stall acknowledge
    localparam logic [7:0] OFF_MASK = 8'h20;  // Tag mask
    localparam logic [7:0] OFF_TSTAT = 8'h24; // Tag completion status
    // Opcodes in cmd[7:0]
    localparam logic [7:0] OP_PUT = 8'h20;
    localparam logic [7:0] OP_GET = 8'h40;
    localparam logic [7:0] OP_PUTL = 8'h24;
    localparam logic [7:0] OP_GETL = 8'h44;
    // Limits and geometry
    localparam logic [14:0] MAX_XFER = 15'h4000;  // 16 KB
    localparam logic [4:0] TAG_MAX = 5'h1F;       // Tags 0-31
    localparam logic [4:0] QW_BYTES = 5'h10;      // Quadword
    localparam logic [7:0] LINE_BYTES = 8'h80;    // 8 quadwords
    localparam logic [3:0] ELEM_BYTES = 4'h8;     // List element
    localparam int MAX_ELEMS = 2048;
    localparam int STALL_BIT = 31;                // In element size word
    // Status fields
    localparam int ST_STALL = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_ERR = 2;
    localparam int ST_STAG = 8;                   // Stalled tag [12:8]
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // AXI response codes
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

// [src/ldma_lm_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Local memory port: one quadword per access
interface ldma_lm_if #(parameter int AW = 14);
    logic req;               // Access strobe
    logic we;                // Write into local memory
    logic [AW-1:0] qaddr;    // Quadword index
    logic [127:0] wdata;     // Write data
    logic [127:0] rdata;     // Read data, one cycle later
    modport master (output req, we, qaddr, wdata, input rdata);
    modport slave (input req, we, qaddr, wdata, output rdata);
endinterface
`default_nettype wire

// [src/ldma_lmem.sv]
`timescale 1ns/1ps
`default_nettype none
// Local memory array, one quadword wide
module ldma_lmem #(
    parameter int AW = 14
) (
    input wire logic mclk,
    ldma_lm_if.slave lm
);
    logic [127:0] mem [0:(1<<AW)-1]; // Storage
    logic [127:0] rd_q;              // Registered read

    // Synchronous read and write
    always_ff @(posedge mclk) begin
        if (lm.req && lm.we) begin
            mem[lm.qaddr] <= lm.wdata;
        end
        rd_q <= mem[lm.qaddr];
    end
    assign lm.rdata = rd_q;
endmodule // ldma_lmem
`default_nettype wire

// [src/ldma_beat.sv]
`timescale 1ns/1ps
`default_nettype none
// Splits a main-storage span into line-bounded bus request lengths
module ldma_beat (
    input wire logic [31:0] addr,
    input wire logic [14:0] left,
    output logic [7:0] len
);
    import ldma_pkg::*;
    logic [7:0] room;   // Bytes to next line boundary
    assign room = LINE_BYTES - {1'b0, addr[6:0]};
    // Partial line only at the start or end of a transfer
    assign len = ({7'h00, room} > left) ? left[7:0] : room;
endmodule // ldma_beat
`default_nettype wire

// [src/ldma_top.sv]
// Behaviour
// - Each transfer moves at most 16 KB; element size is not checked (low 15 bits, up to 32767 bytes)
// - Put copies local to main, get reverse
// - Local memory walked sequentially by quadwords
// - Tag group lies in 0-31
// - Main address given as two words
// - Only first/last bus request is partial line
// - Only local program issues list commands
// - List holds at most 2048 elements
// - Element: size word with stall, low address
// - Elements processed strictly in stored order
// - Stall flag halts list until event cleared
// - Local address advances per element internally
// - Unaligned element local address rounds up
// - Element transfer may cross 4-GB boundary
// - Tag mask selects groups for status query
`timescale 1ns/1ps
`default_nettype none
module ldma_top #(
    parameter int LAW = 14
) (
    input wire logic mclk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Main storage request port
    output logic ms_req,
    output logic ms_we,
    output logic [63:0] ms_addr,
    output logic [7:0] ms_len,
    output logic [127:0] ms_wdata,
    input wire logic ms_ack,
    input wire logic [127:0] ms_rdata
);
    import ldma_pkg::*;

    typedef enum logic [2:0] {
        LDMA_IDLE = 3'b000,
        LDMA_FETCH = 3'b001,
        LDMA_ELEM = 3'b011,
        LDMA_RDLM = 3'b010,
        LDMA_BUS = 3'b110,
        LDMA_STALL = 3'b111
    } ldma_state_e;

    // Local memory behind the engine
    ldma_lm_if #(.AW(LAW)) lm ();
    ldma_lmem #(.AW(LAW)) u_lmem (.mclk(mclk), .lm(lm));

    // Parameter channels
    logic [31:0] lsa_q, eah_q, eal_q, size_q, mask_q;
    logic [4:0] tag_q;
    // Working command
    ldma_state_e st_q;
    logic list_q, put_q, half_q;
    logic [31:0] cur_lsa_q, list_ptr_q, list_left_q, esize_q;
    logic [63:0] ea_q;
    logic [14:0] left_q;
    logic [4:0] ctag_q, stag_q;
    logic stall_q, err_q;
    logic [31:0] tdone_q;   // Per-tag completion
    // Bus slave
    logic aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;

    // Write capture: address and data in either order
    wire wr_go = aw_q && w_q && !s_bvalid;
    assign s_awready = !aw_q && !s_bvalid;
    assign s_wready = !w_q && !s_bvalid;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= RST_WORD;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_awaddr;
            end else if (wr_go) begin
                aw_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1;
                wd_q <= s_wdata;
            end else if (wr_go) begin
                w_q <= 1'b0;
            end
        end
    end

    // Write decode
    wire wr_known = awa_q inside {OFF_LSA, OFF_EAH, OFF_EAL, OFF_SIZE,
        OFF_TAG, OFF_CMD, OFF_ACK, OFF_MASK};
    wire [7:0] op = wd_q[7:0];
    wire op_list = (op == OP_PUTL) || (op == OP_GETL);
    wire op_ok = op_list || (op == OP_PUT) || (op == OP_GET);
    // Size limits: list size multiple of 8 and at most 2048 elements
    wire size_ok = op_list ? (size_q[2:0] == 3'b000 && size_q != RST_WORD
        && size_q <= MAX_ELEMS * 8 && eal_q[2:0] == 3'b000)
        : (size_q <= {17'h0, MAX_XFER});
    wire cmd_wr = wr_go && awa_q == OFF_CMD;
    wire enq = cmd_wr && st_q == LDMA_IDLE && op_ok && size_ok;
    wire ack_wr = wr_go && awa_q == OFF_ACK && stall_q
        && wd_q[4:0] == stag_q;

    // Response channel
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OK;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp <= (wr_known && !(cmd_wr && !enq)) ? RESP_OK : RESP_ERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // Parameter channel storage, order as software writes them
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lsa_q <= RST_WORD;
            eah_q <= RST_WORD;
            eal_q <= RST_WORD;
            size_q <= RST_WORD;
            tag_q <= 5'h00;
            mask_q <= RST_WORD;
        end else if (wr_go) begin
            if (awa_q == OFF_LSA) lsa_q <= wd_q;
            if (awa_q == OFF_EAH) eah_q <= wd_q;
            if (awa_q == OFF_EAL) eal_q <= wd_q;
            if (awa_q == OFF_SIZE) size_q <= wd_q;
            if (awa_q == OFF_TAG) tag_q <= wd_q[4:0] & TAG_MAX;
            if (awa_q == OFF_MASK) mask_q <= wd_q;
        end
    end

    // Read channel
    wire [31:0] stat_w = {19'h0, stag_q, 5'h0, err_q,
        st_q != LDMA_IDLE, stall_q};
    logic [31:0] rd_mux;
    always_comb begin
        case (s_araddr)
            OFF_LSA: rd_mux = lsa_q;
            OFF_EAH: rd_mux = eah_q;
            OFF_EAL: rd_mux = eal_q;
            OFF_SIZE: rd_mux = size_q;
            OFF_TAG: rd_mux = {27'h0, tag_q};
            OFF_STAT: rd_mux = stat_w;
            OFF_MASK: rd_mux = mask_q;
            OFF_TSTAT: rd_mux = tdone_q & mask_q;
            default: rd_mux = RST_WORD;
        endcase
    end
    wire rd_known = s_araddr inside {OFF_LSA, OFF_EAH, OFF_EAL, OFF_SIZE,
        OFF_TAG, OFF_STAT, OFF_MASK, OFF_TSTAT};
    assign s_arready = !s_rvalid;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_rvalid <= 1'b0;
            s_rdata <= RST_WORD;
            s_rresp <= RESP_OK;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= rd_known ? RESP_OK : RESP_ERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Bus request length for the current address
    wire [7:0] blen;
    ldma_beat u_beat (.addr(ea_q[31:0]), .left(left_q), .len(blen));

    // Local memory drive
    wire [31:0] elem_size = half_q ? lm.rdata[95:64] : lm.rdata[31:0];
    wire [31:0] elem_addr = half_q ? lm.rdata[127:96] : lm.rdata[63:32];
    assign lm.req = (st_q == LDMA_FETCH) || (st_q == LDMA_RDLM)
        || (st_q == LDMA_BUS && ms_ack && !put_q);
    assign lm.we = (st_q == LDMA_BUS) && !put_q;
    assign lm.qaddr = (st_q == LDMA_FETCH) ? list_ptr_q[LAW+3:4]
        : cur_lsa_q[LAW+3:4];
    assign lm.wdata = ms_rdata;

    // Next element local address, rounded to a quadword
    wire [31:0] lsa_up = (cur_lsa_q + 32'h0000_000F) & 32'hFFFF_FFF0;
    // Count already reduced for the element in hand: zero means none left
    wire elem_last = list_left_q == 32'h0000_0000;
    wire fin = (st_q == LDMA_BUS) && ms_ack && left_q == {7'h0, blen};

    // Engine sequencer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q <= LDMA_IDLE;
            list_q <= 1'b0;
            put_q <= 1'b0;
            half_q <= 1'b0;
            cur_lsa_q <= RST_WORD;
            list_ptr_q <= RST_WORD;
            list_left_q <= RST_WORD;
            esize_q <= RST_WORD;
            ea_q <= 64'h0000_0000_0000_0000;
            left_q <= 15'h0000;
            ctag_q <= 5'h00;
            stag_q <= 5'h00;
            stall_q <= 1'b0;
            err_q <= 1'b0;
            tdone_q <= 32'hFFFF_FFFF;
            ms_req <= 1'b0;
            ms_we <= 1'b0;
            ms_addr <= 64'h0000_0000_0000_0000;
            ms_len <= 8'h00;
            ms_wdata <= 128'h0;
        end else begin
            if (cmd_wr) err_q <= !enq;
            case (st_q)
                // Accept a new command
                LDMA_IDLE: begin
                    if (enq) begin
                        list_q <= op_list;
                        put_q <= (op == OP_PUT) || (op == OP_PUTL);
                        ctag_q <= tag_q;
                        tdone_q[tag_q] <= 1'b0;
                        cur_lsa_q <= lsa_q;
                        ea_q <= {eah_q, eal_q};
                        left_q <= size_q[14:0];
                        list_ptr_q <= eal_q;
                        list_left_q <= size_q;
                        half_q <= 1'b0;
                        st_q <= op_list ? LDMA_FETCH
                            : (size_q == RST_WORD ? LDMA_IDLE : LDMA_RDLM);
                        if (!op_list && size_q == RST_WORD)
                            tdone_q[tag_q] <= 1'b1;
                    end
                end
                // Read one list element, size word then address word
                LDMA_FETCH: begin
                    st_q <= LDMA_ELEM;
                    half_q <= list_ptr_q[3];
                end
                LDMA_ELEM: begin
                    esize_q <= elem_size;
                    // Second word is the low main address, first is size
                    ea_q <= {eah_q, elem_addr};
                    left_q <= elem_size[14:0];
                    cur_lsa_q <= lsa_up;
                    list_ptr_q <= list_ptr_q + {28'h0, ELEM_BYTES};
                    list_left_q <= list_left_q - {28'h0, ELEM_BYTES};
                    st_q <= LDMA_RDLM;
                end
                // Read local quadword ahead of a put beat
                LDMA_RDLM: begin
                    if (left_q == 15'h0000) begin
                        st_q <= LDMA_BUS;
                    end else begin
                        st_q <= LDMA_BUS;
                        ms_req <= 1'b1;
                    end
                end
                LDMA_BUS: begin
                    ms_we <= put_q;
                    ms_addr <= ea_q;
                    ms_len <= blen;
                    ms_wdata <= lm.rdata;
                    if (left_q == 15'h0000 || fin) begin
                        ms_req <= 1'b0;
                        if (fin) cur_lsa_q <= cur_lsa_q + {24'h0, blen};
                        if (!list_q) begin
                            st_q <= LDMA_IDLE;
                            tdone_q[ctag_q] <= 1'b1;
                        end else if (esize_q[STALL_BIT]) begin
                            st_q <= LDMA_STALL;
                            stall_q <= 1'b1;
                            stag_q <= ctag_q;
                        end else if (elem_last) begin
                            st_q <= LDMA_IDLE;
                            tdone_q[ctag_q] <= 1'b1;
                        end else begin
                            st_q <= LDMA_FETCH;
                        end
                    end else if (ms_ack) begin
                        // Full 64-bit add lets a transfer cross 4 GB
                        ea_q <= ea_q + {56'h0, blen};
                        left_q <= left_q - {7'h0, blen};
                        cur_lsa_q <= cur_lsa_q + {24'h0, blen};
                        ms_req <= 1'b0;
                        st_q <= LDMA_RDLM;
                    end
                end
                // Hold until software clears the stall event
                LDMA_STALL: begin
                    if (ack_wr) begin
                        stall_q <= 1'b0;
                        st_q <= elem_last ? LDMA_IDLE : LDMA_FETCH;
                        if (elem_last) tdone_q[ctag_q] <= 1'b1;
                    end
                end
                default: st_q <= LDMA_IDLE;
            endcase
        end
    end

    // Checks
    stall_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == LDMA_STALL && !ack_wr |=> st_q == LDMA_STALL)
        else $error("list left stall without acknowledge");
    stall_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == LDMA_STALL |-> stall_q && stag_q == ctag_q)
        else $error("stall event or tag missing");
    line_len_a: assert property (@(posedge mclk) disable iff (!nrst)
        ms_req |-> ms_len <= LINE_BYTES
        && ({1'b0, ms_addr[6:0]} + {1'b0, ms_len}) <= {1'b0, LINE_BYTES})
        else $error("bus request crosses line");
    elem_size_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == LDMA_BUS |-> left_q <= MAX_XFER)
        else $error("transfer exceeds limit");
    dir_a: assert property (@(posedge mclk) disable iff (!nrst)
        ms_req && ms_ack |-> ms_we == put_q)
        else $error("bus direction differs from command");
    lsa_align_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == LDMA_ELEM |=> cur_lsa_q[3:0] == 4'h0)
        else $error("element local address unaligned");
    enq_a: assert property (@(posedge mclk) disable iff (!nrst)
        enq |=> st_q != LDMA_IDLE || $past(size_q) == RST_WORD)
        else $error("opcode write did not start command");
    order_a: assert property (@(posedge mclk) disable iff (!nrst)
        st_q == LDMA_ELEM |=> list_ptr_q == $past(list_ptr_q) + 32'h8)
        else $error("list pointer out of order");
    cv_list: cover property (@(posedge mclk) enq && op_list);
    cv_stall: cover property (@(posedge mclk) ack_wr);
    cv_put: cover property (@(posedge mclk) ms_req && ms_we);
endmodule // ldma_top
`default_nettype wire

// [verif/ldma_ms_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Main storage behind the request port, answers after a random delay
module ldma_ms_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic ms_req,
    input wire logic ms_we,
    input wire logic [63:0] ms_addr,
    input wire logic [127:0] ms_wdata,
    output logic ms_ack,
    output logic [127:0] ms_rdata
);
    logic [127:0] mem [logic [59:0]]; // Quadword store
    int seed = 17; // Delay sequence
    int wait_q; // Cycles left before the answer
    // Preload one quadword
    task automatic load(input logic [63:0] a, input logic [127:0] d);
        mem[a[63:4]] = d;
    endtask
    // One answer per request; data lines never keep stale values
    always @(posedge mclk) begin
        if (!nrst) begin
            ms_ack <= 1'h0;
            ms_rdata <= '0;
            wait_q <= 1;
        end else if (ms_req && !ms_ack && wait_q == 0) begin
            ms_ack <= 1'h1;
            if (ms_we) mem[ms_addr[63:4]] = ms_wdata;
            ms_rdata <= mem.exists(ms_addr[63:4]) ?
                mem[ms_addr[63:4]] : {2{ms_addr}};
        end else begin
            ms_ack <= 1'h0;
            ms_rdata <= ~ms_rdata;
            // Count down only while a request waits
            if (ms_req && !ms_ack) wait_q <= wait_q - 1;
            else wait_q <= 1 + ($random(seed) & (slow ? 7 : 1));
        end
    end
endmodule // ldma_ms_model
`default_nettype wire

// [verif/test_ldma_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ldma_top;
    import ldma_pkg::*;
    typedef struct {logic we; logic [63:0] addr; logic [7:0] len;
        logic chk; logic [127:0] wd;} ldma_exp_s;
    logic mclk = 1'h0, nrst = 1'h0, slow = 1'h0; // Clock, reset, delay
    logic [7:0] s_awaddr = '0, s_araddr = '0; // Bus addresses
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0;
    logic [31:0] s_wdata = '0;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire logic ms_req, ms_we, ms_ack;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    wire logic [63:0] ms_addr;
    wire logic [7:0] ms_len;
    wire logic [127:0] ms_wdata, ms_rdata;
    ldma_exp_s expq[$]; // Expected requests, oldest first
    ldma_exp_s ex; // Request under comparison
    int err_total = 0, checks = 0, seed = 50409;
    logic [31:0] rd, ea, n; // Last read word, scratch
    logic [1:0] rs; // Last response code
    logic [127:0] qw; // Random payload
    always #12.5 mclk = ~mclk;
    ldma_top ldma_top_inst (.mclk, .nrst, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .ms_req, .ms_we, .ms_addr, .ms_len,
        .ms_wdata, .ms_ack, .ms_rdata);
    ldma_ms_model ldma_ms_model_inst (.mclk, .nrst, .slow, .ms_req, .ms_we,
        .ms_addr, .ms_wdata, .ms_ack, .ms_rdata);
    // Verdict and end of run
    task automatic end_sim();
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compare one value
    task automatic cmp(input string nm, input logic [127:0] e,
                       input logic [127:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ta, tw, tb;
        tb = 1'h0;
        @(posedge mclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        while (!tb) begin
            @(negedge mclk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            tb = s_bvalid;
            rs = s_bresp;
            @(posedge mclk);
            if (ta) s_awvalid <= 1'h0;
            if (tw) s_wvalid <= 1'h0;
            if (tb) s_bready <= 1'h0;
        end
        cmp("bresp", er, rs);
    endtask
    // Bus read into rd and rs
    task automatic rdw(input logic [7:0] a);
        logic tr, tv;
        tv = 1'h0;
        @(posedge mclk);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        while (!tv) begin
            @(negedge mclk);
            tr = s_arvalid && s_arready;
            tv = s_rvalid;
            rd = s_rdata;
            rs = s_rresp;
            @(posedge mclk);
            if (tr) s_arvalid <= 1'h0;
            if (tv) s_rready <= 1'h0;
        end
    endtask
    // Read and compare masked word and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er);
        rdw(a);
        cmp("rdata", e, rd & m);
        cmp("rresp", er, rs);
    endtask
    // Poll one status bit until it reaches v
    task automatic wait_stat(input int b, input logic v);
        int i;
        i = 0;
        rdw(OFF_STAT);
        while (rd[b] !== v && i < 2000) begin
            rdw(OFF_STAT);
            i++;
        end
        cmp("status bit", v, rd[b]);
    endtask
    // Channel writes in the fixed order, opcode last
    task automatic cmd(input logic [31:0] lsa, eah, eal, sz, tg,
                       input logic [7:0] op, input logic [1:0] er);
        wr(OFF_LSA, lsa, RESP_OK);
        wr(OFF_EAH, eah, RESP_OK);
        wr(OFF_EAL, eal, RESP_OK);
        wr(OFF_SIZE, sz, RESP_OK);
        wr(OFF_TAG, tg, RESP_OK);
        wr(OFF_CMD, {24'h00_0000, op}, er);
    endtask
    // Expected requests of one span, cut at line edges
    task automatic span(input logic we, input logic [63:0] a,
                        input logic [31:0] sz);
        logic [31:0] c;
        while (sz > 0) begin
            c = 32'h80 - {25'h0, a[6:0]};
            if (c > sz) c = sz;
            expq.push_back('{we, a, c[7:0], 1'h0, '0});
            a += {32'h0, c};
            sz -= c;
        end
    endtask
    // Every accepted request against the oldest note
    always @(posedge mclk) begin
        if (nrst && ms_req && ms_ack) begin
            if (expq.size() == 0) begin
                cmp("unexpected request", 1'h0, 1'h1);
            end else begin
                ex = expq.pop_front();
                cmp("ms_we", ex.we, ms_we);
                cmp("ms_addr", ex.addr, ms_addr);
                cmp("ms_len", ex.len, ms_len);
                if (ex.chk) cmp("ms_wdata", ex.wd, ms_wdata);
            end
        end
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'h1;
        rd_chk(OFF_STAT, 32'hFFFF_FFFF, RST_WORD, RESP_OK);
        rd_chk(8'h28, 32'h0, 32'h0, RESP_ERR);
        wr(8'h2C, 32'h0, RESP_ERR);
        // Get one quadword, then put it back elsewhere
        qw = {$random(seed), $random(seed), $random(seed), $random(seed)};
        ldma_ms_model_inst.load(64'h0000_0001_0000_1000, qw);
        span(1'h0, 64'h0000_0001_0000_1000, 32'h10);
        cmd(0, 1, 32'h1000, 32'h10, 0, OP_GET, RESP_OK);
        wait_stat(ST_BUSY, 1'h0);
        expq.push_back('{1'h1, 64'h2000, 8'h10, 1'h1, qw});
        cmd(0, 0, 32'h2000, 32'h10, 31, OP_PUT, RESP_OK);
        wait_stat(ST_BUSY, 1'h0);
        // Random line offsets and sizes, last one line-aligned at the size limit
        slow = 1'h1;
        for (int i = 0; i < 3; i++) begin
            ea = (i == 2) ? 32'h3000
                : 32'h3000 + 32'(($random(seed) & 7) << 4);
            n = (i == 2) ? 32'h4000 : 32'(16 * (1 + ($random(seed) & 31)));
            span(1'h1, {32'h0, ea}, n);
            cmd(0, 0, ea, n, i, OP_PUT, RESP_OK);
            wait_stat(ST_BUSY, 1'h0);
        end
        // Oversize refused, error flag raised
        cmd(0, 0, 32'h3000, 32'h4010, 0, OP_GET, RESP_ERR);
        rd_chk(OFF_STAT, 32'h4, 32'h4, RESP_OK);
        // List of three, second element stalls and crosses 4 GB
        ldma_ms_model_inst.load(64'h8000,
            128'hFFFF_FFF0_8000_0020_0000_5000_0000_0018);
        ldma_ms_model_inst.load(64'h8010, 128'h0000_7000_0000_0010);
        span(1'h0, 64'h8000, 32'h10);
        cmd(32'h200, 0, 32'h8000, 32'h10, 1, OP_GET, RESP_OK);
        wait_stat(ST_BUSY, 1'h0);
        span(1'h0, 64'h8010, 32'h10);
        cmd(32'h210, 0, 32'h8010, 32'h10, 1, OP_GET, RESP_OK);
        wait_stat(ST_BUSY, 1'h0);
        for (int k = 0; k < 2; k++) begin
            span(k[0], 64'h0000_0001_0000_5000, 32'h18);
            span(k[0], 64'h0000_0001_FFFF_FFF0, 32'h20);
            cmd(32'h300, 1, 32'h200, 32'h18, 5,
                k ? OP_PUTL : OP_GETL, RESP_OK);
            wait_stat(ST_STALL, 1'h1);
            rd_chk(OFF_STAT, 32'h1F03, 32'h0503, RESP_OK);
            wr(OFF_CMD, {24'h00_0000, OP_GET}, RESP_ERR);
            repeat (10) @(posedge mclk);
            cmp("pending", '0, 128'(expq.size()));
            span(k[0], 64'h0000_0001_0000_7000, 32'h10);
            wr(OFF_ACK, 32'h5, RESP_OK);
            wait_stat(ST_BUSY, 1'h0);
        end
        wr(OFF_MASK, 32'h20, RESP_OK);
        rd_chk(OFF_TSTAT, 32'hFFFF_FFFF, 32'h20, RESP_OK);
        cmp("pending", '0, 128'(expq.size()));
        end_sim();
    end
endmodule // test_ldma_top
`default_nettype wire
